// [rtl/rf_mode_pkg.sv]
// Purpose : constants and types for the rf mode control register bank
// Assumes : 50 MHz system clock, apb with 32-bit data
// Notes   : printed offsets are word indices, byte address is index * 4
package rf_mode_pkg;

  // ---------------------------------------------------------------
  // register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [9:0]  IDX_SLEEP_ACK  = 10'h035;
  localparam logic [9:0]  IDX_RF_MODE    = 10'h036;
  localparam logic [9:0]  IDX_SEC_CTRL2  = 10'h037;
  localparam logic [9:0]  IDX_STATUS     = 10'h03a;
  localparam logic [11:0] ADDR_SLEEP_ACK = {IDX_SLEEP_ACK, 2'b00};
  localparam logic [11:0] ADDR_RF_MODE   = {IDX_RF_MODE, 2'b00};
  localparam logic [11:0] ADDR_SEC_CTRL2 = {IDX_SEC_CTRL2, 2'b00};
  localparam logic [11:0] ADDR_STATUS    = {IDX_STATUS, 2'b00};

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned SLEEP_ACK_BIT  = 7;  // sleep_acknowledge
  localparam int unsigned WAKE_LO_MSB    = 6;  // osc_wake_count[6:0]
  localparam int unsigned WAKE_HI_MSB    = 4;  // osc_wake_count[8:7]
  localparam int unsigned WAKE_HI_LSB    = 3;
  localparam int unsigned HOLD_RESET_BIT = 2;  // radio_fsm_hold_reset
  localparam int unsigned FORCE_TX_BIT   = 1;  // force_transmit_state
  localparam int unsigned FORCE_RX_BIT   = 0;  // force_receive_state
  localparam int unsigned DECRYPT_BIT    = 7;  // upper_layer_decrypt
  localparam int unsigned ENCRYPT_BIT    = 6;  // upper_layer_encrypt
  localparam int unsigned SLOT2_MSB      = 5;  // slot2_suite_select
  localparam int unsigned SLOT2_LSB      = 3;
  localparam int unsigned SLOT1_MSB      = 2;  // slot1_suite_select
  localparam int unsigned SLOT1_LSB      = 0;

  // ---------------------------------------------------------------
  // reset values and widths
  // ---------------------------------------------------------------
  localparam int unsigned WAKE_W       = 9;
  localparam logic [8:0]  WAKE_RESET   = 9'h000;
  localparam logic [4:0]  RF_MODE_RST  = 5'h00;
  localparam logic [5:0]  SEC_CTRL_RST = 6'h00;
  localparam int unsigned CAL_CNT_W    = 24;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 50;
  localparam int unsigned CAL_TIME_US     = 192;
  localparam int unsigned CAL_CYCLES_DEF  = CAL_TIME_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // radio control state machine
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    RADIO_HELD = 4'b0001,
    RADIO_IDLE = 4'b0010,
    RADIO_TX   = 4'b0100,
    RADIO_RX   = 4'b1000
  } radio_state_t;

endpackage : rf_mode_pkg

// [rtl/osc_startup_timer.sv]
// Purpose : counts the oscillator start-up time in sleep clock periods
// Assumes : tick is a one-cycle pulse on the system clock
// Notes   : a count of zero reports ready at once
`timescale 1ns/100ps
module osc_startup_timer (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire logic                          start,
  input  wire logic                          clear,
  input  wire logic                          tick,
  input  wire logic [rf_mode_pkg::WAKE_W-1:0] count,
  output logic                               done
);

  logic [rf_mode_pkg::WAKE_W-1:0] cnt_q;
  logic [rf_mode_pkg::WAKE_W-1:0] cnt_d;
  logic                           busy_q;
  logic                           busy_d;
  logic                           done_q;
  logic                           done_d;
  wire logic                      last_tick = busy_q & tick &
                                              (cnt_q == 9'h001);

  // ---------------------------------------------------------------
  // next state: start wins over clear, clear over counting
  // ---------------------------------------------------------------
  assign cnt_d  = start ? count :
                  (busy_q & tick) ? cnt_q - 9'h001 : cnt_q;
  assign busy_d = start ? (count != 9'h000) :
                  clear ? 1'b0 : (busy_q & ~last_tick);
  assign done_d = start ? (count == 9'h000) :
                  clear ? 1'b0 : (done_q | last_tick);
  assign done   = done_q;

  // timer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= 9'h000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

endmodule : osc_startup_timer

// [rtl/rf_mode_control_register.sv]
// Purpose : rf mode control, sleep acknowledge and security control 2
//           registers on apb, with the radio state machine they steer
// Assumes : 50 MHz clk, sleep_clock and wake_pin are asynchronous pins
// Notes   : one wait state on every apb access
// Notes on behaviour
// - wake count is nine bits: two in control, seven in sleep register
// - wake count counts sleep clock periods, resets to zero, 0x05F advised
// - wake count times main oscillator start-up after leaving sleep
// - hold-reset bit one keeps radio machine in reset, zero lets it run
// - force-transmit bit drives radio machine into transmit state
// - writing sleep acknowledge one sleeps device; bit clears itself
`timescale 1ns/100ps
module rf_mode_control_register #(
  parameter int unsigned CAL_CYCLES = rf_mode_pkg::CAL_CYCLES_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleep_clock,
  input  wire logic        wake_pin,
  output logic      [8:0]  osc_wake_count,
  output logic             osc_enable,
  output logic             osc_ready,
  output logic             cal_busy,
  output logic      [3:0]  radio_state,
  output logic             decrypt_start,
  output logic             encrypt_start,
  output logic      [2:0]  slot2_suite_select,
  output logic      [2:0]  slot1_suite_select
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [31:0]               prdata_q;
  logic                      pready_q;
  logic                      pslverr_q;
  logic [6:0]                wake_lo_q;
  logic [1:0]                wake_hi_q;
  logic                      hold_q;
  logic                      ftx_q;
  logic                      frx_q;
  logic [2:0]                slot2_q;
  logic [2:0]                slot1_q;
  logic                      dec_q;
  logic                      enc_q;
  logic                      sleeping_q;
  logic                      awake_q;
  logic                      cal_busy_q;
  logic [rf_mode_pkg::CAL_CNT_W-1:0] cal_cnt_q;
  logic [rf_mode_pkg::CAL_CNT_W-1:0] cal_cnt_d;
  logic [2:0]                sclk_sync_q;
  logic [2:0]                wake_sync_q;
  logic                      timer_done;
  rf_mode_pkg::radio_state_t state_q;
  rf_mode_pkg::radio_state_t state_d;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire logic        access    = psel & penable;
  wire logic        pready_d  = access & ~pready_q;
  // a write lands on the edge at which the master sees pready high
  wire logic        wr_fire   = access & pready_q & pwrite;
  wire logic        hit_sleep = (paddr == rf_mode_pkg::ADDR_SLEEP_ACK);
  wire logic        hit_mode  = (paddr == rf_mode_pkg::ADDR_RF_MODE);
  wire logic        hit_sec   = (paddr == rf_mode_pkg::ADDR_SEC_CTRL2);
  wire logic        hit_stat  = (paddr == rf_mode_pkg::ADDR_STATUS);
  wire logic        hit_any   = hit_sleep | hit_mode | hit_sec | hit_stat;
  wire logic        wr_sleep  = wr_fire & hit_sleep;
  wire logic        wr_mode   = wr_fire & hit_mode;
  wire logic        wr_sec    = wr_fire & hit_sec;
  wire logic [7:0]  wdat      = pwdata[7:0];

  // sleep acknowledge and security start bits read back as zero
  wire logic [7:0]  rd_sleep  = {1'b0, wake_lo_q};
  // reserved bits 7..5 read as zero and are never stored
  wire logic [7:0]  rd_mode   = {3'b000, wake_hi_q, hold_q, ftx_q,
                                 frx_q};
  wire logic [7:0]  rd_sec    = {2'b00, slot2_q, slot1_q};
  wire logic [7:0]  rd_stat   = {1'b0, cal_busy_q, osc_ready,
                                 sleeping_q, state_q};
  wire logic [7:0]  rd_byte   = hit_sleep ? rd_sleep :
                                hit_mode  ? rd_mode  :
                                hit_sec   ? rd_sec   :
                                hit_stat  ? rd_stat  : 8'h00;

  // ---------------------------------------------------------------
  // apb answer: one wait state, data captured with pready
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      pready_q  <= pready_d;
      pslverr_q <= pready_d & ~hit_any;
      if (pready_d) begin
        prdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers, third stage only for edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_sync_q <= 3'b000;
      wake_sync_q <= 3'b000;
    end else if (ce) begin
      sclk_sync_q <= {sclk_sync_q[1:0], sleep_clock};
      wake_sync_q <= {wake_sync_q[1:0], wake_pin};
    end
  end

  wire logic sleep_tick = sclk_sync_q[1] & ~sclk_sync_q[2];
  wire logic wake_rise  = wake_sync_q[1] & ~wake_sync_q[2];

  // ---------------------------------------------------------------
  // wake count registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_lo_q <= rf_mode_pkg::WAKE_RESET[6:0];
      wake_hi_q <= rf_mode_pkg::WAKE_RESET[8:7];
    end else if (ce) begin
      if (wr_sleep) begin
        wake_lo_q <= wdat[rf_mode_pkg::WAKE_LO_MSB:0];
      end
      if (wr_mode) begin
        wake_hi_q <= wdat[rf_mode_pkg::WAKE_HI_MSB:
                          rf_mode_pkg::WAKE_HI_LSB];
      end
    end
  end

  // ---------------------------------------------------------------
  // radio mode control bits
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_q <= rf_mode_pkg::RF_MODE_RST[rf_mode_pkg::HOLD_RESET_BIT];
      ftx_q  <= rf_mode_pkg::RF_MODE_RST[rf_mode_pkg::FORCE_TX_BIT];
      frx_q  <= rf_mode_pkg::RF_MODE_RST[rf_mode_pkg::FORCE_RX_BIT];
    end else if (ce && wr_mode) begin
      hold_q <= wdat[rf_mode_pkg::HOLD_RESET_BIT];
      ftx_q  <= wdat[rf_mode_pkg::FORCE_TX_BIT];
      frx_q  <= wdat[rf_mode_pkg::FORCE_RX_BIT];
    end
  end

  // ---------------------------------------------------------------
  // security control 2: suite selects and one-cycle start pulses
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot2_q <= rf_mode_pkg::SEC_CTRL_RST[5:3];
      slot1_q <= rf_mode_pkg::SEC_CTRL_RST[2:0];
      dec_q   <= 1'b0;
      enc_q   <= 1'b0;
    end else if (ce) begin
      dec_q <= wr_sec & wdat[rf_mode_pkg::DECRYPT_BIT];
      enc_q <= wr_sec & wdat[rf_mode_pkg::ENCRYPT_BIT];
      if (wr_sec) begin
        slot2_q <= wdat[rf_mode_pkg::SLOT2_MSB:rf_mode_pkg::SLOT2_LSB];
        slot1_q <= wdat[rf_mode_pkg::SLOT1_MSB:rf_mode_pkg::SLOT1_LSB];
      end
    end
  end

  // ---------------------------------------------------------------
  // sleep: set by the acknowledge write, ended by a wake pin edge;
  // the acknowledge bit itself is never stored, so it reads zero
  // ---------------------------------------------------------------
  wire logic sleep_req = wr_sleep & wdat[rf_mode_pkg::SLEEP_ACK_BIT];
  wire logic wake_go   = sleeping_q & wake_rise & ~sleep_req;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleeping_q <= 1'b0;
    end else if (ce) begin
      if (sleep_req) begin
        sleeping_q <= 1'b1;
      end else if (wake_go) begin
        sleeping_q <= 1'b0;
      end
    end
  end

  // oscillator enable kept in a flop of its own, low while asleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awake_q <= 1'b1;
    end else if (ce) begin
      if (sleep_req) begin
        awake_q <= 1'b0;
      end else if (wake_go) begin
        awake_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // oscillator start-up timer, loaded with the wake count on wake
  // ---------------------------------------------------------------
  osc_startup_timer u_osc_timer (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .start (wake_go),
    .clear (sleep_req),
    .tick  (sleep_tick),
    .count ({wake_hi_q, wake_lo_q}),
    .done  (timer_done)
  );

  // ---------------------------------------------------------------
  // calibration window after the hold-reset bit is released
  // ---------------------------------------------------------------
  // a second release inside the window restarts the full count
  wire logic cal_start = wr_mode & hold_q &
                         ~wdat[rf_mode_pkg::HOLD_RESET_BIT];
  assign cal_cnt_d = cal_start ?
                     rf_mode_pkg::CAL_CNT_W'(CAL_CYCLES) :
                     (cal_cnt_q != '0) ?
                     cal_cnt_q - rf_mode_pkg::CAL_CNT_W'(1) : cal_cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_cnt_q  <= '0;
      cal_busy_q <= 1'b0;
    end else if (ce) begin
      cal_cnt_q  <= cal_cnt_d;
      cal_busy_q <= (cal_cnt_d != '0);
    end
  end

  // ---------------------------------------------------------------
  // radio control state machine: held, then idle, then transmit or receive, transmit first
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      rf_mode_pkg::RADIO_HELD: begin
        if (!hold_q && !sleeping_q) begin
          state_d = rf_mode_pkg::RADIO_IDLE;
        end
      end
      rf_mode_pkg::RADIO_IDLE,
      rf_mode_pkg::RADIO_TX,
      rf_mode_pkg::RADIO_RX: begin
        if (hold_q || sleeping_q) begin
          state_d = rf_mode_pkg::RADIO_HELD;
        end else if (ftx_q) begin
          state_d = rf_mode_pkg::RADIO_TX;
        end else if (frx_q) begin
          state_d = rf_mode_pkg::RADIO_RX;
        end else begin
          state_d = rf_mode_pkg::RADIO_IDLE;
        end
      end
      default: begin
        state_d = rf_mode_pkg::RADIO_HELD;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= rf_mode_pkg::RADIO_HELD;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all taken from flip-flops
  // ---------------------------------------------------------------
  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign osc_wake_count     = {wake_hi_q, wake_lo_q};
  assign osc_enable         = awake_q;
  assign osc_ready          = timer_done;
  assign cal_busy           = cal_busy_q;
  assign radio_state        = state_q;
  assign decrypt_start      = dec_q;
  assign encrypt_start      = enc_q;
  assign slot2_suite_select = slot2_q;
  assign slot1_suite_select = slot1_q;

endmodule : rf_mode_control_register

// [testbench/rf_mode_monitor.sv]
// Purpose : protocol and behaviour checks on the rf mode register bank
// Assumes : one clock domain, ce held high by the bench
// Notes   : sees only the top-level ports, attached by bind
`timescale 1ns/100ps
module rf_mode_monitor #(
  parameter int unsigned CAL_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [8:0]  osc_wake_count,
  input wire logic        osc_enable,
  input wire logic        osc_ready,
  input wire logic        cal_busy,
  input wire logic [3:0]  radio_state
);
  // ---------------------------------------------------------------
  // helper logic and sequences
  // ---------------------------------------------------------------
  logic [23:0] busy_cnt_q;

  // counts consecutive calibration cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) busy_cnt_q <= 24'h000000;
    else busy_cnt_q <= cal_busy ? busy_cnt_q + 24'h000001 : 24'h000000;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // completed good write, then one each for the rf mode and sleep acknowledge registers
  sequence s_done;
    psel && penable && pready && pwrite && !pslverr;
  endsequence
  sequence s_mode_wr;
    s_done ##0 paddr == rf_mode_pkg::ADDR_RF_MODE;
  endsequence
  sequence s_sleep_wr;
    s_done ##0 paddr == rf_mode_pkg::ADDR_SLEEP_ACK;
  endsequence

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 0)
    else $error("read data upper bits not zero");
  wake_low_a: assert property (s_sleep_wr |=>
    osc_wake_count[6:0] == $past(pwdata[6:0]))
    else $error("wake count low bits not taken");
  wake_high_a: assert property (s_mode_wr |=>
    osc_wake_count[8:7] == $past(pwdata[4:3]))
    else $error("wake count high bits not taken");
  hold_state_a: assert property (s_mode_wr ##0 pwdata[2]
    |-> ##[1:3] radio_state == 4'b0001)
    else $error("radio not held");
  tx_state_a: assert property (s_mode_wr ##0 pwdata[2:1] == 2'b01
    && osc_enable |-> ##[1:3] radio_state == 4'b0100)
    else $error("radio not in transmit");
  rx_state_a: assert property (s_mode_wr ##0 pwdata[2:0]
    == 3'b001 && osc_enable |-> ##[1:3] radio_state == 4'b1000)
    else $error("radio not in receive");
  cal_len_a: assert property ($fell(cal_busy)
    |-> busy_cnt_q == CAL_CYCLES)
    else $error("calibration window wrong length");
  sleep_entry_a: assert property (s_sleep_wr ##0 pwdata[7]
    |-> ##[1:3] !osc_enable && !osc_ready)
    else $error("sleep not entered");
endmodule : rf_mode_monitor

// [testbench/sleep_side_model.sv]
// Purpose : sleep oscillator and external wake source beside the device
// Assumes : free-running sleep clock, unrelated in phase to clk
// Notes   : wake_pin follows wake_req on a sleep clock edge
`timescale 1ns/100ps
module sleep_side_model #(
  parameter int HALF_NS = 200
) (
  input  wire logic wake_req,
  output logic      sleep_clock,
  output logic      wake_pin
);
  // sleep clock, the unit in which the wake count is measured
  initial begin
    sleep_clock = 1'b0;
    #7;
    forever #(HALF_NS) sleep_clock = ~sleep_clock;
  end

  // wake source switches on a sleep clock edge, like a slow part
  initial wake_pin = 1'b0;
  always @(posedge sleep_clock) wake_pin <= wake_req;
endmodule : sleep_side_model

// [testbench/rf_mode_control_register_tb_top.sv]
// Purpose : register-level tests of the rf mode control bank
// Assumes : ce tied high, calibration shortened to CAL_CYCLES
// Notes   : apb master tasks; checks count into err_count
`timescale 1ns/100ps
module rf_mode_control_register_tb_top;
  localparam int unsigned CAL_CYCLES = 20;
  localparam logic [11:0] MODE = rf_mode_pkg::ADDR_RF_MODE;
  localparam logic [11:0] SLP  = rf_mode_pkg::ADDR_SLEEP_ACK;
  localparam logic [11:0] SEC  = rf_mode_pkg::ADDR_SEC_CTRL2;
  logic        clk, rst, ce, psel, penable, pwrite, wake_req, err_seen;
  logic        pready, pslverr, sleep_clock, wake_pin, osc_enable;
  logic        osc_ready, cal_busy, decrypt_start, encrypt_start;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0]  osc_wake_count;
  logic [3:0]  radio_state;
  logic [2:0]  slot2, slot1;
  int          err_count, n_checks, i;

  // ---------------------------------------------------------------
  // clock, design and partner
  // ---------------------------------------------------------------
  initial clk = 1'b0;
  always #10 clk = ~clk;

  rf_mode_control_register #(.CAL_CYCLES(CAL_CYCLES)) dut (
    .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_clock(sleep_clock),
    .wake_pin(wake_pin), .osc_wake_count(osc_wake_count),
    .osc_enable(osc_enable), .osc_ready(osc_ready), .cal_busy(cal_busy),
    .radio_state(radio_state), .decrypt_start(decrypt_start),
    .encrypt_start(encrypt_start), .slot2_suite_select(slot2),
    .slot1_suite_select(slot1));

  sleep_side_model partner (.wake_req(wake_req),
    .sleep_clock(sleep_clock), .wake_pin(wake_pin));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer, held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(what, exp, rd);
  endtask : rd_chk

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {rst, ce} = 2'b11;
    {psel, penable, pwrite, wake_req} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    err_count = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk("wake count", 32'h0, osc_wake_count);
    chk("radio idle", 32'h2, radio_state);
    rd_chk("mode reset", MODE, 32'h00);
    rd_chk("sec2 reset", SEC, 32'h00);
    // reserved bits dropped, hold wins over both force bits
    apb(1'b1, MODE, 32'hff);
    rd_chk("mode rw", MODE, 32'h1f);
    chk("radio held", 32'h1, radio_state);
    apb(1'b1, MODE, 32'h04);
    apb(1'b1, MODE, 32'h00);
    repeat (2) @(negedge clk);
    chk("cal busy", 32'h1, cal_busy);
    repeat (CAL_CYCLES + 4) @(negedge clk);
    chk("cal over", 32'h0, cal_busy);
    chk("radio run", 32'h2, radio_state);
    apb(1'b1, MODE, 32'h06);
    apb(1'b1, MODE, 32'h02);
    repeat (3) @(negedge clk);
    chk("radio tx", 32'h4, radio_state);
    apb(1'b1, MODE, 32'h11);
    apb(1'b1, SLP, 32'h5f);
    repeat (2) @(negedge clk);
    chk("wake count", 32'h15f, osc_wake_count);
    chk("radio rx", 32'h8, radio_state);
    // sleep, self-clearing bit, then wake after the start-up count
    apb(1'b1, MODE, 32'h00);
    apb(1'b1, SLP, 32'h85);
    repeat (3) @(negedge clk);
    chk("osc off", 32'h0, osc_enable);
    rd_chk("sleep bit", SLP, 32'h05);
    rd_chk("status", rf_mode_pkg::ADDR_STATUS, 32'h11);
    wake_req <= 1'b1;
    wait (wake_pin === 1'b1);
    for (i = 0; i < 400 && osc_ready !== 1'b1; i++) @(negedge clk);
    chk("osc ready", 32'h1, osc_ready);
    chk("ready delay", 32'h1, i >= 72);
    chk("ready late", 32'h1, i <= 108);
    chk("radio awake", 32'h2, radio_state);
    // unmapped address and security control fields
    apb(1'b0, 12'h000, 32'h00000000);
    chk("slverr", 32'h1, err_seen);
    chk("unmapped", 32'h0, rd);
    apb(1'b1, SEC, 32'hda);
    @(negedge clk);
    chk("crypt pulse", 32'h3, {decrypt_start, encrypt_start});
    @(negedge clk);
    chk("pulse end", 32'h0, {decrypt_start, encrypt_start});
    rd_chk("sec2 rw", SEC, 32'h1a);
    chk("slots", 32'h1a, {slot2, slot1});
    final_report();
  end

  // cuts a hang short
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule : rf_mode_control_register_tb_top

bind rf_mode_control_register rf_mode_monitor #(.CAL_CYCLES(CAL_CYCLES))
  mon (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .osc_wake_count(osc_wake_count),
  .osc_enable(osc_enable), .osc_ready(osc_ready), .cal_busy(cal_busy),
  .radio_state(radio_state));
